// [logic/lso_pkg.sv]
// Package with register map, field layout, reset values and timing counts for the load step block
package lso_pkg;

  // Timing
  localparam int CLK_KHZ          = 100_000;
  localparam int PULSE_MS         = 250;
  localparam int PULSE_CYCLES     = CLK_KHZ * PULSE_MS;
  localparam int SEC_MS           = 1000;
  localparam int SEC_CYCLES       = CLK_KHZ * SEC_MS;
  localparam int FLASH_ZERO_MIN   = 2;
  localparam int FLASH_ZERO_SEC   = FLASH_ZERO_MIN * 60;
  localparam int HOUR_SEC         = 3600;

  // Sizes
  localparam int NUM_STEPS        = 5;
  localparam int NUM_FIN          = 5;
  localparam int NUM_DOUT         = 8;
  localparam int SEC_W            = 16;
  localparam int FLASH_W          = 20;
  localparam int PWR_W            = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_INCFG    = 8'h04;
  localparam logic [7:0] OFS_ADD_LVL  = 8'h08;
  localparam logic [7:0] OFS_SUB_LVL  = 8'h0c;
  localparam logic [7:0] OFS_CON_ST   = 8'h10;
  localparam logic [7:0] OFS_CON_WT   = 8'h14;
  localparam logic [7:0] OFS_SHD_ST   = 8'h18;
  localparam logic [7:0] OFS_SHD_WT   = 8'h1c;
  localparam logic [7:0] OFS_FLASH    = 8'h20;
  localparam logic [7:0] OFS_OUTSEL   = 8'h24;
  localparam logic [7:0] OFS_STATUS   = 8'h28;
  localparam logic [7:0] OFS_ALARM    = 8'h2c;

  // Control bits
  localparam int CTRL_RS_EN       = 0;
  localparam int CTRL_DAS_EN      = 1;
  localparam int CTRL_DSIM        = 2;
  localparam int CTRL_PRI_EN      = 3;
  localparam int CTRL_FS_EN       = 4;

  // Function input indices
  localparam int FIN_RS           = 0;
  localparam int FIN_DAS          = 1;
  localparam int FIN_SIM          = 2;
  localparam int FIN_PRI          = 3;
  localparam int FIN_FS           = 4;

  localparam logic [1:0] ACT_SILENT = 2'h3;

  // Output function codes
  localparam logic [3:0] OUTF_OFF     = 4'h0;
  localparam logic [3:0] OUTF_FLASH   = 4'h1;
  localparam logic [3:0] OUTF_MFAIL   = 4'h2;
  localparam logic [3:0] OUTF_MASTER  = 4'h3;
  localparam logic [3:0] OUTF_FSTART  = 4'h4;

  // Reset values
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
  localparam logic [15:0] RST_ADD    = 16'h0064;
  localparam logic [15:0] RST_SUB    = 16'h0320;
  localparam logic [15:0] RST_DELAY  = 16'h000a;

  typedef struct packed {
    logic       nc;
    logic       neg;
    logic [1:0] action;
  } lso_fin_cfg_t;

  typedef struct packed {
    logic       mainsOk;
    logic       mainsLed;
    logic       forceStart;
    logic       master;
  } lso_mains_t;

endpackage : lso_pkg

// [logic/lso_load_step.sv]
// Load step manager, mains override and flashing relay with a Wishbone register file
//
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module lso_load_step
  import lso_pkg::*;
#(
  parameter int SEC_CNT   = SEC_CYCLES,
  parameter int PULSE_CNT = PULSE_CYCLES
)(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Plant inputs
  input  wire logic [PWR_W-1:0]    genPower,
  input  wire logic                mainsMeasOk,
  input  wire logic                genRunning,
  input  wire logic [NUM_FIN-1:0]  funcIn,
  // Plant outputs
  output logic [NUM_STEPS-1:0]     loadAdd,
  output logic [NUM_STEPS-1:0]     loadSub,
  output logic                     mainsOk,
  output logic                     mainsLed,
  output logic                     forceStart,
  output logic                     roleMaster,
  output logic [NUM_DOUT-1:0]      digOut
);

  // Register file
  logic [4:0]                   ctrl_reg, ctrl_next;
  lso_fin_cfg_t [NUM_FIN-1:0]   incfg_reg, incfg_next;
  logic [PWR_W-1:0]             addLvl_reg, addLvl_next;
  logic [PWR_W-1:0]             subLvl_reg, subLvl_next;
  logic [SEC_W-1:0]             conSt_reg, conSt_next;
  logic [SEC_W-1:0]             conWt_reg, conWt_next;
  logic [SEC_W-1:0]             shdSt_reg, shdSt_next;
  logic [SEC_W-1:0]             shdWt_reg, shdWt_next;
  logic [7:0]                   flashOn_reg, flashOn_next;
  logic [7:0]                   flashOff_reg, flashOff_next;
  logic [4*NUM_DOUT-1:0]        outSel_reg, outSel_next;
  logic [NUM_FIN-1:0]           alarm_reg, alarm_next;
  logic [31:0]                  rdat_reg, rdat_next;
  logic                         ack_reg, ack_next;

  // Timers and state
  logic [31:0]                  pre_reg, pre_next;
  logic                         secTick_reg, secTick_next;
  logic [SEC_W-1:0]             addSt_reg, addSt_next;
  logic [SEC_W-1:0]             addWt_reg, addWt_next;
  logic [SEC_W-1:0]             subSt_reg, subSt_next;
  logic [SEC_W-1:0]             subWt_reg, subWt_next;
  logic [2:0]                   steps_reg, steps_next;
  logic [31:0]                  pulse_reg, pulse_next;
  logic [NUM_STEPS-1:0]         add_reg, add_next;
  logic [NUM_STEPS-1:0]         sub_reg, sub_next;
  logic [FLASH_W-1:0]           flashCnt_reg, flashCnt_next;
  logic                         flash_reg, flash_next;
  logic [FLASH_W-1:0]           blkCnt_reg, blkCnt_next;
  logic                         blk_reg, blk_next;
  logic                         simPrev_reg, simPrev_next;
  logic                         failPrev_reg, failPrev_next;
  lso_mains_t                   mains_reg, mains_next;
  logic [NUM_DOUT-1:0]          dout_reg, dout_next;

  logic [NUM_FIN-1:0]           finAct;
  logic                         wbWr;
  logic                         wbRd;
  logic [FLASH_W-1:0]           onSec;
  logic [FLASH_W-1:0]           offSec;

  // Input conditioning
  always_comb
  begin
    for (int i = 0; i < NUM_FIN; i++)
    begin
      finAct[i] = funcIn[i] ^ incfg_reg[i].nc ^ incfg_reg[i].neg;
    end
  end

  // Flash periods in seconds
  always_comb
  begin
    onSec  = (flashOn_reg == 8'h00) ? FLASH_W'(FLASH_ZERO_SEC)
                                     : FLASH_W'(flashOn_reg * HOUR_SEC);
    offSec = (flashOff_reg == 8'h00) ? FLASH_W'(FLASH_ZERO_SEC)
                                      : FLASH_W'(flashOff_reg * HOUR_SEC);
  end

  assign wbWr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg;
  assign wbRd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_reg;

  // Register file next state
  always_comb
  begin
    ctrl_next     = ctrl_reg;
    incfg_next    = incfg_reg;
    addLvl_next   = addLvl_reg;
    subLvl_next   = subLvl_reg;
    conSt_next    = conSt_reg;
    conWt_next    = conWt_reg;
    shdSt_next    = shdSt_reg;
    shdWt_next    = shdWt_reg;
    flashOn_next  = flashOn_reg;
    flashOff_next = flashOff_reg;
    outSel_next   = outSel_reg;
    alarm_next    = alarm_reg;
    rdat_next     = rdat_reg;
    ack_next      = wb_cyc_i & wb_stb_i & ~ack_reg;
    if (wbWr)
    begin
      case (wb_adr_i)
        OFS_CTRL:    if (wb_sel_i[0]) ctrl_next = wb_dat_i[4:0];
        OFS_INCFG:
        begin
          if (wb_sel_i[0]) incfg_next[1:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) incfg_next[3:2] = wb_dat_i[15:8];
          if (wb_sel_i[2]) incfg_next[4]   = wb_dat_i[19:16];
        end
        OFS_ADD_LVL:
        begin
          if (wb_sel_i[0]) addLvl_next[7:0]  = wb_dat_i[7:0];
          if (wb_sel_i[1]) addLvl_next[15:8] = wb_dat_i[15:8];
        end
        OFS_SUB_LVL:
        begin
          if (wb_sel_i[0]) subLvl_next[7:0]  = wb_dat_i[7:0];
          if (wb_sel_i[1]) subLvl_next[15:8] = wb_dat_i[15:8];
        end
        OFS_CON_ST:
        begin
          if (wb_sel_i[0]) conSt_next[7:0]  = wb_dat_i[7:0];
          if (wb_sel_i[1]) conSt_next[15:8] = wb_dat_i[15:8];
        end
        OFS_CON_WT:
        begin
          if (wb_sel_i[0]) conWt_next[7:0]  = wb_dat_i[7:0];
          if (wb_sel_i[1]) conWt_next[15:8] = wb_dat_i[15:8];
        end
        OFS_SHD_ST:
        begin
          if (wb_sel_i[0]) shdSt_next[7:0]  = wb_dat_i[7:0];
          if (wb_sel_i[1]) shdSt_next[15:8] = wb_dat_i[15:8];
        end
        OFS_SHD_WT:
        begin
          if (wb_sel_i[0]) shdWt_next[7:0]  = wb_dat_i[7:0];
          if (wb_sel_i[1]) shdWt_next[15:8] = wb_dat_i[15:8];
        end
        OFS_FLASH:
        begin
          if (wb_sel_i[0]) flashOn_next  = wb_dat_i[7:0];
          if (wb_sel_i[1]) flashOff_next = wb_dat_i[15:8];
        end
        OFS_OUTSEL:
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (wb_sel_i[b]) outSel_next[8*b +: 8] = wb_dat_i[8*b +: 8];
          end
        end
        default: ;
      endcase
    end
    // Alarm clear by writing one; a new event wins
    if (wbWr && wb_adr_i == OFS_ALARM && wb_sel_i[0])
    begin
      alarm_next = alarm_reg & ~wb_dat_i[NUM_FIN-1:0];
    end
    for (int i = 0; i < NUM_FIN; i++)
    begin
      if (finAct[i] && incfg_reg[i].action != ACT_SILENT) alarm_next[i] = 1'b1;
    end
    if (wbRd)
    begin
      case (wb_adr_i)
        OFS_CTRL:    rdat_next = {27'h0000000, ctrl_reg};
        OFS_INCFG:   rdat_next = {12'h000, incfg_reg};
        OFS_ADD_LVL: rdat_next = {16'h0000, addLvl_reg};
        OFS_SUB_LVL: rdat_next = {16'h0000, subLvl_reg};
        OFS_CON_ST:  rdat_next = {16'h0000, conSt_reg};
        OFS_CON_WT:  rdat_next = {16'h0000, conWt_reg};
        OFS_SHD_ST:  rdat_next = {16'h0000, shdSt_reg};
        OFS_SHD_WT:  rdat_next = {16'h0000, shdWt_reg};
        OFS_FLASH:   rdat_next = {16'h0000, flashOff_reg, flashOn_reg};
        OFS_OUTSEL:  rdat_next = outSel_reg;
        OFS_STATUS:  rdat_next = {18'h00000, blk_reg, flash_reg, mains_reg, finAct, steps_reg};
        OFS_ALARM:   rdat_next = {27'h0000000, alarm_reg};
        default:     rdat_next = RST_ZERO;
      endcase
    end
  end

  // Load step next state
  always_comb
  begin
    pre_next     = pre_reg;
    secTick_next = 1'b0;
    addSt_next   = addSt_reg;
    addWt_next   = addWt_reg;
    subSt_next   = subSt_reg;
    subWt_next   = subWt_reg;
    steps_next   = steps_reg;
    pulse_next   = pulse_reg;
    add_next     = add_reg;
    sub_next     = sub_reg;
    if (pre_reg >= 32'(SEC_CNT - 1))
    begin
      pre_next     = 32'h0000_0000;
      secTick_next = 1'b1;
    end
    else
    begin
      pre_next = pre_reg + 32'h0000_0001;
    end
    // Start timers restart when power recrosses
    if (genPower >= addLvl_reg) addSt_next = '0;
    else if (secTick_reg && addSt_reg != '1) addSt_next = addSt_reg + 1'b1;
    if (genPower <= subLvl_reg) subSt_next = '0;
    else if (secTick_reg && subSt_reg != '1) subSt_next = subSt_reg + 1'b1;
    if (secTick_reg && addWt_reg != '1) addWt_next = addWt_reg + 1'b1;
    if (secTick_reg && subWt_reg != '1) subWt_next = subWt_reg + 1'b1;
    // Pulse timing
    if (add_reg != '0 || sub_reg != '0)
    begin
      if (pulse_reg >= 32'(PULSE_CNT - 1))
      begin
        add_next   = '0;
        sub_next   = '0;
        pulse_next = 32'h0000_0000;
      end
      else
      begin
        pulse_next = pulse_reg + 32'h0000_0001;
      end
    end
    else if (genPower < addLvl_reg && addSt_reg >= conSt_reg && addWt_reg >= conWt_reg
             && steps_reg < 3'(NUM_STEPS))
    begin
      add_next[steps_reg] = 1'b1;
      steps_next          = steps_reg + 3'h1;
      addSt_next          = '0;
      addWt_next          = '0;
    end
    else if (genPower > subLvl_reg && subSt_reg >= shdSt_reg && subWt_reg >= shdWt_reg
             && steps_reg != 3'h0)
    begin
      sub_next[steps_reg - 3'h1] = 1'b1;
      steps_next                 = steps_reg - 3'h1;
      subSt_next                 = '0;
      subWt_next                 = '0;
    end
  end

  // Mains decision, flash relay and outputs next state
  always_comb
  begin
    flashCnt_next = flashCnt_reg;
    flash_next    = flash_reg;
    blkCnt_next   = blkCnt_reg;
    blk_next      = blk_reg;
    simPrev_next  = finAct[FIN_SIM];
    failPrev_next = ~mains_reg.mainsOk;
    mains_next    = mains_reg;
    if (secTick_reg)
    begin
      if (flashCnt_reg + 1'b1 >= (flash_reg ? onSec : offSec))
      begin
        flashCnt_next = '0;
        flash_next    = ~flash_reg;
      end
      else
      begin
        flashCnt_next = flashCnt_reg + 1'b1;
      end
    end
    // Simulation blocked for on-time when applied while running
    if (finAct[FIN_SIM] && !simPrev_reg && genRunning)
    begin
      blk_next    = 1'b1;
      blkCnt_next = '0;
    end
    else if (blk_reg && secTick_reg)
    begin
      if (blkCnt_reg + 1'b1 >= onSec) blk_next = 1'b0;
      blkCnt_next = blkCnt_reg + 1'b1;
    end
    // Mains override priority
    if (ctrl_reg[CTRL_RS_EN])
    begin
      mains_next.mainsOk  = ~finAct[FIN_RS];
      mains_next.mainsLed = ~finAct[FIN_RS];
    end
    else if (ctrl_reg[CTRL_DAS_EN] && finAct[FIN_DAS])
    begin
      mains_next.mainsOk  = 1'b1;
      mains_next.mainsLed = 1'b1;
    end
    else if (ctrl_reg[CTRL_DSIM] && finAct[FIN_SIM] && !blk_next)
    begin
      mains_next.mainsOk  = 1'b1;
      mains_next.mainsLed = 1'b1;
    end
    else
    begin
      mains_next.mainsOk  = mainsMeasOk;
      mains_next.mainsLed = mainsMeasOk;
    end
    mains_next.forceStart = ctrl_reg[CTRL_FS_EN] & finAct[FIN_FS] & ~ctrl_reg[CTRL_RS_EN];
    if (!mains_reg.mainsOk && !failPrev_reg)
    begin
      mains_next.master = ~ctrl_reg[CTRL_PRI_EN] | finAct[FIN_PRI];
    end
    for (int o = 0; o < NUM_DOUT; o++)
    begin
      case (outSel_reg[4*o +: 4])
        OUTF_FLASH:  dout_next[o] = flash_reg;
        OUTF_MFAIL:  dout_next[o] = ~mains_reg.mainsOk;
        OUTF_MASTER: dout_next[o] = mains_reg.master;
        OUTF_FSTART: dout_next[o] = mains_reg.forceStart;
        default:     dout_next[o] = 1'b0;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ctrl_reg     <= '0;
      incfg_reg    <= '0;
      addLvl_reg   <= RST_ADD;
      subLvl_reg   <= RST_SUB;
      conSt_reg    <= RST_DELAY;
      conWt_reg    <= RST_DELAY;
      shdSt_reg    <= RST_DELAY;
      shdWt_reg    <= RST_DELAY;
      flashOn_reg  <= '0;
      flashOff_reg <= '0;
      outSel_reg   <= RST_ZERO;
      alarm_reg    <= '0;
      rdat_reg     <= RST_ZERO;
      ack_reg      <= 1'b0;
      pre_reg      <= RST_ZERO;
      secTick_reg  <= 1'b0;
      addSt_reg    <= '0;
      addWt_reg    <= '1;
      subSt_reg    <= '0;
      subWt_reg    <= '1;
      steps_reg    <= '0;
      pulse_reg    <= RST_ZERO;
      add_reg      <= '0;
      sub_reg      <= '0;
      flashCnt_reg <= '0;
      flash_reg    <= 1'b0;
      blkCnt_reg   <= '0;
      blk_reg      <= 1'b0;
      simPrev_reg  <= 1'b0;
      failPrev_reg <= 1'b1;
      mains_reg    <= 4'h0;
      dout_reg     <= '0;
    end
    else
    begin
      ctrl_reg     <= ctrl_next;
      incfg_reg    <= incfg_next;
      addLvl_reg   <= addLvl_next;
      subLvl_reg   <= subLvl_next;
      conSt_reg    <= conSt_next;
      conWt_reg    <= conWt_next;
      shdSt_reg    <= shdSt_next;
      shdWt_reg    <= shdWt_next;
      flashOn_reg  <= flashOn_next;
      flashOff_reg <= flashOff_next;
      outSel_reg   <= outSel_next;
      alarm_reg    <= alarm_next;
      rdat_reg     <= rdat_next;
      ack_reg      <= ack_next;
      pre_reg      <= pre_next;
      secTick_reg  <= secTick_next;
      addSt_reg    <= addSt_next;
      addWt_reg    <= addWt_next;
      subSt_reg    <= subSt_next;
      subWt_reg    <= subWt_next;
      steps_reg    <= steps_next;
      pulse_reg    <= pulse_next;
      add_reg      <= add_next;
      sub_reg      <= sub_next;
      flashCnt_reg <= flashCnt_next;
      flash_reg    <= flash_next;
      blkCnt_reg   <= blkCnt_next;
      blk_reg      <= blk_next;
      simPrev_reg  <= simPrev_next;
      failPrev_reg <= failPrev_next;
      mains_reg    <= mains_next;
      dout_reg     <= dout_next;
    end
  end

  // Outputs
  assign wb_dat_o   = rdat_reg;
  assign wb_ack_o   = ack_reg;
  assign loadAdd    = add_reg;
  assign loadSub    = sub_reg;
  assign mainsOk    = mains_reg.mainsOk;
  assign mainsLed   = mains_reg.mainsLed;
  assign forceStart = mains_reg.forceStart;
  assign roleMaster = mains_reg.master;
  assign digOut     = dout_reg;

endmodule : lso_load_step

// [sim/lso_load_step_checker.sv]
// Checker for bus answers, step pulses and mains outputs
`timescale 1ns/1ps
module lso_load_step_checker
  import lso_pkg::*;
#(
  parameter int SEC_CNT   = SEC_CYCLES,
  parameter int PULSE_CNT = PULSE_CYCLES
)(
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 sys_rst,
  // Bus
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_ack_o,
  // Plant outputs
  input wire logic [NUM_STEPS-1:0] loadAdd,
  input wire logic [NUM_STEPS-1:0] loadSub,
  input wire logic                 mainsOk,
  input wire logic                 mainsLed,
  input wire logic                 roleMaster
);
  logic [9:0]  pv;
  logic        start;
  logic        anyReg;
  logic [31:0] lenReg;
  logic [31:0] lenNext;
  logic [2:0]  stepsReg;
  logic [2:0]  stepsNext;
  assign pv = {loadAdd, loadSub};
  assign start = |pv && !anyReg;
  always_comb
  begin
    lenNext = |pv ? lenReg + 32'h1 : 32'h0;
    stepsNext = stepsReg;
    if (start && |loadAdd) stepsNext = stepsReg + 3'h1;
    if (start && |loadSub) stepsNext = stepsReg - 3'h1;
  end
  always_ff @(posedge clk_sys)
  begin
    anyReg <= sys_rst ? 1'b0 : |pv;
    lenReg <= sys_rst ? 32'h0 : lenNext;
    stepsReg <= sys_rst ? 3'h0 : stepsNext;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_pulse_len: assert property ($fell(|pv) |-> lenReg == PULSE_CNT)
    else $error("step pulse length wrong");
  chk_pulse_onehot: assert property ($onehot0(pv))
    else $error("more than one step output active");
  chk_pulse_hold: assert property (|pv |=> pv == $past(pv) || pv == 10'h0)
    else $error("pulse switched outputs");
  chk_add_order: assert property (start && |loadAdd |-> loadAdd == (5'h1 << stepsReg))
    else $error("add pulse on wrong step");
  chk_sub_order: assert property (start && |loadSub |->
    stepsReg != 3'h0 && loadSub == (5'h1 << (stepsReg - 3'h1)))
    else $error("remove pulse on wrong step");
  chk_led_mains: assert property (mainsLed == mainsOk)
    else $error("mains indicator differs from decision");
  chk_master_capture: assert property ($changed(roleMaster) |->
    !mainsOk && ($past(mainsOk) || $past(mainsOk, 2)))
    else $error("role changed without mains failure");
  chk_reset_quiet: assert property (@(posedge clk_sys) disable iff (1'b0)
    sys_rst |=> pv == 10'h0 && !mainsOk && !roleMaster && !wb_ack_o)
    else $error("outputs active in reset");
  cov_add: cover property (start && loadAdd[4]);
  cov_sub: cover property (start && loadSub[0]);
  cov_master: cover property ($rose(roleMaster));
endmodule : lso_load_step_checker

bind lso_load_step lso_load_step_checker #(.SEC_CNT(SEC_CNT), .PULSE_CNT(PULSE_CNT)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .loadAdd(loadAdd), .loadSub(loadSub), .mainsOk(mainsOk),
  .mainsLed(mainsLed), .roleMaster(roleMaster));

// [sim/lso_contactors.sv]
// Load contactor bank that closes or opens one step per pulse and sets genset power
`timescale 1ns/1ps
module lso_contactors
  import lso_pkg::*;
#(
  parameter logic [PWR_W-1:0] STEP_KW = 16'h0010
)(
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 sys_rst,
  // Relay pulses
  input wire logic [NUM_STEPS-1:0] loadAdd,
  input wire logic [NUM_STEPS-1:0] loadSub,
  // Plant
  input wire logic [PWR_W-1:0]     demand,
  output logic     [2:0]           steps,
  output logic     [PWR_W-1:0]     genPower
);
  logic       addReg;
  logic       subReg;
  logic [2:0] stepsNext;
  always_comb
  begin
    stepsNext = steps;
    if (|loadAdd && !addReg) stepsNext = steps + 3'h1;
    if (|loadSub && !subReg) stepsNext = steps - 3'h1;
  end
  always_ff @(posedge clk_sys)
  begin
    addReg <= sys_rst ? 1'b0 : |loadAdd;
    subReg <= sys_rst ? 1'b0 : |loadSub;
    steps <= sys_rst ? 3'h0 : stepsNext;
  end
  assign genPower = demand + {13'h0, steps} * STEP_KW;
endmodule : lso_contactors

// [sim/lso_load_step_tb.sv]
// Testbench for the load step and start override block
`timescale 1ns/1ps
module lso_load_step_tb;
  import lso_pkg::*;
  localparam int SECN = 20;
  logic                 clk_sys = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]           wb_adr_i = 8'h0;
  logic [3:0]           wb_sel_i = 4'h0;
  logic [31:0]          wb_dat_i = 32'h0, wb_dat_o;
  logic                 wb_ack_o, mainsOk, mainsLed, forceStart, roleMaster, prevAny = 1'b0;
  logic [PWR_W-1:0]     genPower, demand = 16'h0080;
  logic                 mainsMeasOk = 1'b0, genRunning = 1'b0;
  logic [NUM_FIN-1:0]   funcIn = 5'h0;
  logic [NUM_STEPS-1:0] loadAdd, loadSub;
  logic [NUM_DOUT-1:0]  digOut;
  logic [2:0]           steps;
  logic [31:0]          expQ[$], mskQ[$], mk;
  logic [7:0]           ra[6] = '{OFS_CTRL, OFS_ADD_LVL, OFS_SUB_LVL, OFS_CON_ST, OFS_SHD_WT, 8'h30};
  logic [31:0]          rv[6] = '{32'h0, 32'h64, 32'h320, 32'ha, 32'ha, 32'h0};
  int                   failures = 0, tests_run = 0, cyc = 0, addT = 0, subT = 0, seed = 32'h0a9b;
  always #5 clk_sys = ~clk_sys;
  lso_load_step #(.SEC_CNT(SECN), .PULSE_CNT(5)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .genPower(genPower), .mainsMeasOk(mainsMeasOk), .genRunning(genRunning), .funcIn(funcIn),
    .loadAdd(loadAdd), .loadSub(loadSub), .mainsOk(mainsOk), .mainsLed(mainsLed),
    .forceStart(forceStart), .roleMaster(roleMaster), .digOut(digOut));
  lso_contactors u_plant (.clk_sys(clk_sys), .sys_rst(sys_rst), .loadAdd(loadAdd),
    .loadSub(loadSub), .demand(demand), .steps(steps), .genPower(genPower));
  task automatic final_report();
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic note(input logic [31:0] v);
    expQ.push_back(v);
    mskQ.push_back(32'hffffffff);
  endtask : note
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     input logic [31:0] msk);
    int n;
    n = 0;
    if (!we) expQ.push_back(dat);
    if (!we) mskQ.push_back(msk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= we ? dat : 32'h0;
    do begin @(posedge clk_sys); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic wait_steps(input logic [2:0] s);
    int n;
    n = 0;
    while (steps !== s && n < 2000) begin @(posedge clk_sys); n++; end
    if (n >= 2000) failures++;
    repeat (200) @(posedge clk_sys);
  endtask : wait_steps
  function automatic logic [31:0] mains_exp(input logic [4:0] c, input logic [4:0] a,
                                            input logic meas);
    logic ok;
    ok = c[CTRL_RS_EN] ? !a[FIN_RS] : (c[CTRL_DAS_EN] && a[FIN_DAS]) || (c[CTRL_DSIM] && a[FIN_SIM]) || meas;
    return {20'h0, ok, ok, c[CTRL_FS_EN] && a[FIN_FS] && !c[CTRL_RS_EN], 1'b0, a, 3'h0};
  endfunction : mains_exp
  // Result watcher: bus reads and the start of each step pulse
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (wb_ack_o === 1'b1 && !wb_we_i)
    begin
      if (expQ.size() == 0) chk(32'h1, 32'h0);
      else
      begin
        mk = mskQ.pop_front();
        chk(wb_dat_o & mk, expQ.pop_front() & mk);
      end
    end
    if (|{loadAdd, loadSub} && !prevAny)
    begin
      if (expQ.size() == 0) chk(32'h1, 32'h0);
      else chk({22'h0, loadAdd, loadSub}, expQ.pop_front() & mskQ.pop_front());
      if (|loadAdd && addT > 0) chk(32'(cyc - addT > 2 * SECN), 32'h1);
      if (|loadSub && subT > 0) chk(32'(cyc - subT > 2 * SECN), 32'h1);
      if (|loadAdd) addT = cyc;
      if (|loadSub) subT = cyc;
    end
    prevAny <= |{loadAdd, loadSub};
  end
  initial
  begin
    #800000;
    failures++;
    final_report();
  end
  initial
  begin
    logic [4:0]  c;
    logic [4:0]  f;
    logic [4:0]  a;
    logic [19:0] ic;
    logic        m;
    logic        v;
    int          n;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 6; i++) bus(1'b0, ra[i], rv[i], 32'hffffffff);
    bus(1'b1, OFS_STATUS, 32'hffffffff, 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0, 32'h7);
    bus(1'b1, OFS_CON_ST, 32'h1, 32'h0);
    bus(1'b1, OFS_CON_WT, 32'h3, 32'h0);
    bus(1'b1, OFS_SHD_ST, 32'h1, 32'h0);
    bus(1'b1, OFS_SHD_WT, 32'h3, 32'h0);
    bus(1'b1, OFS_ADD_LVL, 32'h40, 32'h0);
    bus(1'b1, OFS_SUB_LVL, 32'hffff, 32'h0);
    for (int k = 0; k < 4; k++) note({22'h0, 5'h1 << k, 5'h0});
    demand <= 16'h0;
    wait_steps(3'h4);
    bus(1'b0, OFS_STATUS, 32'h4, 32'h7);
    note({22'h0, 5'h10, 5'h0});
    bus(1'b1, OFS_ADD_LVL, 32'hffff, 32'h0);
    wait_steps(3'h5);
    bus(1'b0, OFS_STATUS, 32'h5, 32'h7);
    bus(1'b1, OFS_ADD_LVL, 32'h0, 32'h0);
    bus(1'b1, OFS_SUB_LVL, 32'h100, 32'h0);
    for (int k = 4; k >= 0; k--) note({27'h0, 5'h1 << k});
    demand <= 16'hff00;
    wait_steps(3'h0);
    bus(1'b0, OFS_STATUS, 32'h0, 32'h7);
    for (int i = 0; i < 24; i++)
    begin
      c = 5'($random(seed));
      ic = (20'($random(seed)) & 20'hccccc) | 20'h33333;
      f = 5'($random(seed));
      m = 1'($random(seed));
      bus(1'b1, OFS_CTRL, {27'h0, c}, 32'h0);
      bus(1'b1, OFS_INCFG, {12'h0, ic}, 32'h0);
      funcIn <= f;
      mainsMeasOk <= m;
      repeat (3) @(posedge clk_sys);
      for (int j = 0; j < 5; j++) a[j] = f[j] ^ ic[4 * j + 3] ^ ic[4 * j + 2];
      bus(1'b0, OFS_STATUS, mains_exp(c, a, m), 32'h0ef8);
    end
    funcIn <= 5'h0;
    bus(1'b0, OFS_ALARM, 32'h0, 32'h1f);
    bus(1'b1, OFS_INCFG, 32'h0, 32'h0);
    funcIn <= 5'h10;
    repeat (3) @(posedge clk_sys);
    bus(1'b0, OFS_ALARM, 32'h10, 32'h1f);
    funcIn <= 5'h0;
    bus(1'b1, OFS_ALARM, 32'h1f, 32'h0);
    bus(1'b0, OFS_ALARM, 32'h0, 32'h1f);
    bus(1'b1, OFS_INCFG, 32'h33333, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h9, 32'h0);
    for (int p = 0; p < 2; p++)
    begin
      funcIn <= {1'b0, 1'(p), 3'h0};
      repeat (4) @(posedge clk_sys);
      funcIn <= {1'b0, 1'(p), 3'h1};
      repeat (4) @(posedge clk_sys);
      bus(1'b0, OFS_STATUS, {23'h0, 1'(p), 8'h0}, 32'h100);
    end
    genRunning <= 1'b1;
    mainsMeasOk <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h4, 32'h0);
    funcIn <= 5'h4;
    repeat (3) @(posedge clk_sys);
    bus(1'b0, OFS_STATUS, 32'h2000, 32'h2800);
    bus(1'b1, OFS_OUTSEL, 32'h1001, 32'h0);
    bus(1'b1, OFS_FLASH, 32'h0, 32'h0);
    for (int r = 0; r < 2; r++)
    begin
      n = 0;
      v = digOut[0];
      while (digOut[0] === v && n < 3000) begin @(posedge clk_sys); n++; end
    end
    chk(n, 120 * SECN);
    chk({31'h0, digOut[3]}, {31'h0, digOut[0]});
    chk({31'h0, digOut[1]}, 32'h0);
    final_report();
  end
endmodule : lso_load_step_tb
